// ===== logic/flash_iap_defines.svh
`ifndef FLASH_IAP_DEFINES_SVH
`define FLASH_IAP_DEFINES_SVH

// register offsets
`define OFS_CTRL 4'h0
`define OFS_CLEAR 4'h1
`define OFS_ADDR_LO 4'h2
`define OFS_ADDR_HI 4'h3
`define OFS_W0_LO 4'h4
`define OFS_W0_HI 4'h5
`define OFS_W1_LO 4'h6
`define OFS_W1_HI 4'h7
`define OFS_W2_LO 4'h8
`define OFS_W2_HI 4'h9
`define OFS_W3_LO 4'ha
`define OFS_W3_HI 4'hb

// control register fields
`define CTRL_ENABLED_BIT 7
`define CTRL_MODE_MSB 6
`define CTRL_MODE_LSB 4
`define CTRL_TRIGGER_BIT 3
`define CTRL_START_BIT 2
`define CLEAR_BIT 0
`define REG_RESET 8'h00

// operation modes
`define MODE_WRITE 3'h0
`define MODE_ERASE 3'h1
`define MODE_UNLOCK 3'h6

// unlock key
`define KEY_W1_LO 8'h00
`define KEY_W2_LO 8'h0d
`define KEY_W3_LO 8'hc3
`define KEY_W1_HI 8'h04
`define KEY_W2_HI 8'h09
`define KEY_W3_HI 8'h40

// timing
`define CLK_PERIOD_NS 4
`define PROG_TIME_NS 2200000
`define PROG_CYCLES (`PROG_TIME_NS / `CLK_PERIOD_NS)
`define UNLOCK_CYCLES 1024
`define PAGE_WORDS 32

`endif

// ===== logic/flash_iap_pkg.sv
package flash_iap_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } bus_req_type;

    typedef struct packed {
        logic erase;
        logic prog;
        logic [7:0] page;
    } flash_cmd_type;

    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_ERASE = 2'b01,
        OP_PROG = 2'b10
    } op_state_type;

endpackage

// ===== logic/interval_timer.sv
`timescale 1ns/1ns
`default_nettype none

module interval_timer #(
    parameter int unsigned CYCLES = 4,
    parameter int W = $clog2(CYCLES + 1)
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // control
    input wire logic start,
    output logic run_q,
    output logic done_q
);

    localparam logic [W-1:0] LAST = W'(CYCLES - 1);
    logic [W-1:0] cnt_q;

    // run stays high for exactly CYCLES cycles, then done pulses once
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start && !run_q) begin
                run_q <= 1'b1;
                cnt_q <= LAST;
            end else if (run_q) begin
                if (cnt_q == '0) begin
                    run_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ===== logic/flash_iap_erase_write_unlock.sv
// Notes on behaviour
// - six key byte registers, read/write, reset zero
// - setting trigger starts the unlock timer
// - key is 00 0d c3 / 04 09 40
// - timer expiry clears trigger regardless of key
// - correct key sets enabled flag; wrong leaves low
// - writing zero to enabled flag disables at once, except while trigger is set and the correct key has been written
// - erase and write launch only while enabled
// - 32-word buffer maps to page address bits 12:5
// - each loaded word below the last advances buffer address
// - address stops at last word of page
// - mode 001 plus start erases addressed page
// - mode 000 plus start programs buffer to page
// - cpu stalled while operation runs
// - start bit held about 2.2 ms
// - software cannot set the enabled flag
// - high byte write loads word, bumps address
// - buffer clear bit self-clears when done
`timescale 1ns/1ns
`default_nettype none
`include "flash_iap_defines.svh"

module flash_iap_erase_write_unlock #(
    parameter int unsigned PROG_CYCLES = `PROG_CYCLES,
    parameter int unsigned UNLOCK_CYCLES = `UNLOCK_CYCLES,
    parameter int unsigned PAGE_WORDS = `PAGE_WORDS
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // register port
    input wire flash_iap_pkg::bus_req_type bus_req,
    output logic [7:0] reg_rdata_q,
    // flash array side
    output flash_iap_pkg::flash_cmd_type flash_cmd_q,
    input wire logic [4:0] flash_buf_idx,
    output logic [15:0] flash_buf_data_q,
    output logic flash_buf_loaded_q,
    // cpu side
    output logic cpu_stall_q
);

    localparam logic [4:0] LAST_WORD = 5'(PAGE_WORDS - 1);

    logic enabled_q, trigger_q, start_q, clear_q;
    logic [2:0] mode_q;
    logic [5:0] key_seen_q;
    logic [12:0] addr_q;
    logic [7:0] w0_lo_q, w0_hi_q, w1_lo_q, w1_hi_q;
    logic [7:0] w2_lo_q, w2_hi_q, w3_lo_q, w3_hi_q;
    logic [15:0] buf_q [PAGE_WORDS];
    logic [PAGE_WORDS-1:0] loaded_q;
    flash_iap_pkg::op_state_type op_q;

    // decode
    wire wr_ctrl = bus_req.wr && bus_req.addr == `OFS_CTRL;
    wire wr_clear = bus_req.wr && bus_req.addr == `OFS_CLEAR;
    wire wr_alo = bus_req.wr && bus_req.addr == `OFS_ADDR_LO;
    wire wr_ahi = bus_req.wr && bus_req.addr == `OFS_ADDR_HI;
    wire load_word = bus_req.wr && bus_req.addr == `OFS_W0_HI;
    wire [5:0] key_wr = bus_req.wr
        ? 6'h01 << (bus_req.addr - `OFS_W1_LO) : 6'h00;
    wire [2:0] wr_mode = bus_req.wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    wire wr_start_bit = bus_req.wdata[`CTRL_START_BIT];

    wire unlock_go = wr_ctrl && bus_req.wdata[`CTRL_TRIGGER_BIT]
        && wr_mode == `MODE_UNLOCK && !trigger_q;
    wire key_match = w1_lo_q == `KEY_W1_LO && w2_lo_q == `KEY_W2_LO
        && w3_lo_q == `KEY_W3_LO && w1_hi_q == `KEY_W1_HI
        && w2_hi_q == `KEY_W2_HI && w3_hi_q == `KEY_W3_HI;
    // a key left in the registers from earlier cannot unlock later
    wire unlock_hit = trigger_q && key_match && &key_seen_q;
    wire sw_disable = wr_ctrl && !bus_req.wdata[`CTRL_ENABLED_BIT];
    wire launch_ok = enabled_q && !start_q && wr_ctrl && wr_start_bit;
    wire launch_erase = launch_ok && wr_mode == `MODE_ERASE;
    wire launch_prog = launch_ok && wr_mode == `MODE_WRITE;
    wire launch = launch_erase || launch_prog;
    wire at_last = addr_q[4:0] == LAST_WORD;

    logic unlock_run, unlock_done, prog_run, prog_done;

    interval_timer #(
        .CYCLES(UNLOCK_CYCLES)
    ) u_unlock_timer (
        .mclk(mclk),
        .nrst(nrst),
        .start(unlock_go),
        .run_q(unlock_run),
        .done_q(unlock_done)
    );

    interval_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_prog_timer (
        .mclk(mclk),
        .nrst(nrst),
        .start(launch),
        .run_q(prog_run),
        .done_q(prog_done)
    );

    // control bits; hardware set of the enabled flag wins over a clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            enabled_q <= 1'b0;
            mode_q <= 3'h0;
            trigger_q <= 1'b0;
            key_seen_q <= 6'h00;
        end else begin
            if (wr_ctrl)
                mode_q <= wr_mode;
            key_seen_q <= unlock_go ? 6'h00 : key_seen_q | key_wr;
            if (unlock_hit)
                enabled_q <= 1'b1;
            else if (sw_disable)
                enabled_q <= 1'b0;
            if (unlock_go)
                trigger_q <= 1'b1;
            else if (unlock_done)
                trigger_q <= 1'b0;
        end
    end

    // operation sequencing
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            start_q <= 1'b0;
            cpu_stall_q <= 1'b0;
            op_q <= flash_iap_pkg::OP_IDLE;
            flash_cmd_q <= '0;
        end else begin
            unique case (op_q)
                flash_iap_pkg::OP_IDLE: begin
                    if (launch) begin
                        start_q <= 1'b1;
                        cpu_stall_q <= 1'b1;
                        flash_cmd_q.erase <= launch_erase;
                        flash_cmd_q.prog <= launch_prog;
                        flash_cmd_q.page <= addr_q[12:5];
                        op_q <= launch_erase ? flash_iap_pkg::OP_ERASE
                                             : flash_iap_pkg::OP_PROG;
                    end
                end
                flash_iap_pkg::OP_ERASE, flash_iap_pkg::OP_PROG: begin
                    if (prog_done) begin
                        start_q <= 1'b0;
                        cpu_stall_q <= 1'b0;
                        flash_cmd_q.erase <= 1'b0;
                        flash_cmd_q.prog <= 1'b0;
                        op_q <= flash_iap_pkg::OP_IDLE;
                    end
                end
                default: op_q <= flash_iap_pkg::OP_IDLE;
            endcase
        end
    end

    // address pair; auto increment stops at the page end so a long
    // load can never spill into the neighbouring page
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            addr_q <= 13'h0000;
        end else if (wr_alo) begin
            addr_q[7:0] <= bus_req.wdata;
        end else if (wr_ahi) begin
            addr_q[12:8] <= bus_req.wdata[4:0];
        end else if (load_word && !at_last) begin
            addr_q <= addr_q + 13'h0001;
        end
    end

    // data byte registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            w0_lo_q <= `REG_RESET;
            w0_hi_q <= `REG_RESET;
            w1_lo_q <= `REG_RESET;
            w1_hi_q <= `REG_RESET;
            w2_lo_q <= `REG_RESET;
            w2_hi_q <= `REG_RESET;
            w3_lo_q <= `REG_RESET;
            w3_hi_q <= `REG_RESET;
        end else if (bus_req.wr) begin
            unique case (bus_req.addr)
                `OFS_W0_LO: w0_lo_q <= bus_req.wdata;
                `OFS_W0_HI: w0_hi_q <= bus_req.wdata;
                `OFS_W1_LO: w1_lo_q <= bus_req.wdata;
                `OFS_W1_HI: w1_hi_q <= bus_req.wdata;
                `OFS_W2_LO: w2_lo_q <= bus_req.wdata;
                `OFS_W2_HI: w2_hi_q <= bus_req.wdata;
                `OFS_W3_LO: w3_lo_q <= bus_req.wdata;
                `OFS_W3_HI: w3_hi_q <= bus_req.wdata;
                default: ;
            endcase
        end
    end

    // write buffer; clearing takes one cycle for all words at once
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            clear_q <= 1'b0;
            loaded_q <= '0;
            for (int i = 0; i < PAGE_WORDS; i++)
                buf_q[i] <= 16'h0000;
        end else begin
            clear_q <= wr_clear && bus_req.wdata[`CLEAR_BIT];
            if (clear_q) begin
                loaded_q <= '0;
                for (int i = 0; i < PAGE_WORDS; i++)
                    buf_q[i] <= 16'h0000;
            end else if (load_word) begin
                buf_q[addr_q[4:0]] <= {bus_req.wdata, w0_lo_q};
                loaded_q[addr_q[4:0]] <= 1'b1;
            end
        end
    end

    // flash array reads the buffer by index, one cycle latency
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            flash_buf_data_q <= 16'h0000;
            flash_buf_loaded_q <= 1'b0;
        end else begin
            flash_buf_data_q <= buf_q[flash_buf_idx];
            flash_buf_loaded_q <= loaded_q[flash_buf_idx];
        end
    end

    // read mux
    logic [7:0] rd_mux;
    always_comb begin
        unique case (bus_req.addr)
            `OFS_CTRL: rd_mux = {enabled_q, mode_q, trigger_q, start_q, 2'b00};
            `OFS_CLEAR: rd_mux = {7'h00, clear_q};
            `OFS_ADDR_LO: rd_mux = addr_q[7:0];
            `OFS_ADDR_HI: rd_mux = {3'h0, addr_q[12:8]};
            `OFS_W0_LO: rd_mux = w0_lo_q;
            `OFS_W0_HI: rd_mux = w0_hi_q;
            `OFS_W1_LO: rd_mux = w1_lo_q;
            `OFS_W1_HI: rd_mux = w1_hi_q;
            `OFS_W2_LO: rd_mux = w2_lo_q;
            `OFS_W2_HI: rd_mux = w2_hi_q;
            `OFS_W3_LO: rd_mux = w3_lo_q;
            `OFS_W3_HI: rd_mux = w3_hi_q;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            reg_rdata_q <= 8'h00;
        else if (bus_req.rd)
            reg_rdata_q <= rd_mux;
        else
            reg_rdata_q <= 8'h00;
    end

    // assertions
    property p_unlock_set;
        @(posedge mclk) disable iff (!nrst)
        unlock_hit |=> enabled_q;
    endproperty
    a_unlock_set: assert property (p_unlock_set)
        else $error("correct key did not enable");

    property p_no_sw_set;
        @(posedge mclk) disable iff (!nrst)
        !enabled_q && !unlock_hit |=> !enabled_q;
    endproperty
    a_no_sw_set: assert property (p_no_sw_set)
        else $error("enabled flag set without key");

    property p_sw_clear;
        @(posedge mclk) disable iff (!nrst)
        sw_disable && !unlock_hit |=> !enabled_q;
    endproperty
    a_sw_clear: assert property (p_sw_clear)
        else $error("enabled flag not cleared");

    property p_trigger_window;
        @(posedge mclk) disable iff (!nrst)
        unlock_go |=> trigger_q && unlock_run;
    endproperty
    a_trigger_window: assert property (p_trigger_window)
        else $error("trigger did not start timer");

    property p_trigger_end;
        @(posedge mclk) disable iff (!nrst)
        unlock_done |=> !trigger_q;
    endproperty
    a_trigger_end: assert property (p_trigger_end)
        else $error("trigger not cleared on timeout");

    property p_locked_refuse;
        @(posedge mclk) disable iff (!nrst)
        wr_ctrl && wr_start_bit && !enabled_q && !start_q |=> !start_q;
    endproperty
    a_locked_refuse: assert property (p_locked_refuse)
        else $error("operation launched while locked");

    property p_launch_hold;
        @(posedge mclk) disable iff (!nrst)
        launch |=> (start_q && cpu_stall_q)[*8];
    endproperty
    a_launch_hold: assert property (p_launch_hold)
        else $error("start or stall dropped early");

    property p_erase_cmd;
        @(posedge mclk) disable iff (!nrst)
        launch_erase |=> flash_cmd_q.erase && !flash_cmd_q.prog
            && flash_cmd_q.page == $past(addr_q[12:5]);
    endproperty
    a_erase_cmd: assert property (p_erase_cmd)
        else $error("erase command wrong");

    property p_done_clears;
        @(posedge mclk) disable iff (!nrst)
        prog_done |=> !start_q && !cpu_stall_q && !flash_cmd_q.prog;
    endproperty
    a_done_clears: assert property (p_done_clears)
        else $error("start not cleared at end");

    property p_addr_inc;
        @(posedge mclk) disable iff (!nrst)
        load_word && !at_last |=> addr_q == $past(addr_q) + 13'h0001;
    endproperty
    a_addr_inc: assert property (p_addr_inc)
        else $error("address did not advance");

    property p_addr_stop;
        @(posedge mclk) disable iff (!nrst)
        load_word && at_last |=> $stable(addr_q);
    endproperty
    a_addr_stop: assert property (p_addr_stop)
        else $error("address crossed page end");

    property p_buf_load;
        @(posedge mclk) disable iff (!nrst)
        load_word && !clear_q |=> buf_q[$past(addr_q[4:0])]
            == {$past(bus_req.wdata), $past(w0_lo_q)};
    endproperty
    a_buf_load: assert property (p_buf_load)
        else $error("buffer word not loaded");

    property p_clear_done;
        @(posedge mclk) disable iff (!nrst)
        clear_q && !load_word |=> loaded_q == '0;
    endproperty
    a_clear_done: assert property (p_clear_done)
        else $error("buffer not cleared");

    c_unlock: cover property (@(posedge mclk) disable iff (!nrst)
        unlock_hit ##1 enabled_q);
    c_erase: cover property (@(posedge mclk) disable iff (!nrst)
        launch_erase);
    c_prog_done: cover property (@(posedge mclk) disable iff (!nrst)
        prog_done && op_q == flash_iap_pkg::OP_PROG);
    c_page_end: cover property (@(posedge mclk) disable iff (!nrst)
        load_word && at_last);

endmodule

`default_nettype wire

// ===== test/flash_array_model.sv
`timescale 1ns/1ns
`default_nettype none

module flash_array_model (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // block side
    input wire flash_iap_pkg::flash_cmd_type flash_cmd,
    output logic [4:0] buf_idx,
    input wire logic [15:0] buf_data,
    input wire logic buf_loaded
);
    logic [15:0] buf_seen [32];
    logic loaded_seen [32];
    logic [15:0] mem [256][32];
    logic [4:0] prev_idx;
    logic prog_was;

    // the buffer is scanned without pause, one word per cycle, so each snapshot word is refreshed every 32 cycles
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            buf_idx <= 5'h00;
            prev_idx <= 5'h00;
            prog_was <= 1'b0;
        end else begin
            buf_seen[prev_idx] <= buf_data;
            loaded_seen[prev_idx] <= buf_loaded;
            prev_idx <= buf_idx;
            buf_idx <= buf_idx + 5'h01;
            prog_was <= flash_cmd.prog;
            if (flash_cmd.erase) begin
                for (int i = 0; i < 32; i++) begin
                    mem[flash_cmd.page][i] <= 16'h0000;
                end
            end
            if (prog_was && !flash_cmd.prog) begin
                for (int i = 0; i < 32; i++) begin
                    if (loaded_seen[i]) begin
                        mem[flash_cmd.page][i] <= buf_seen[i];
                    end
                end
            end
        end
    end
endmodule

`default_nettype wire

// ===== test/tb_flash_iap_erase_write_unlock.sv
`timescale 1ns/1ns
`default_nettype none
`include "flash_iap_defines.svh"

module tb_flash_iap_erase_write_unlock;
    localparam int PR = 20;
    localparam int UL = 16;
    logic mclk;
    logic nrst;
    flash_iap_pkg::bus_req_type bus_req;
    logic [7:0] reg_rdata_q;
    flash_iap_pkg::flash_cmd_type flash_cmd_q;
    logic [4:0] flash_buf_idx;
    logic [15:0] flash_buf_data_q;
    logic flash_buf_loaded_q;
    logic cpu_stall_q;
    int error_cnt;
    int tests_run;
    logic [7:0] rv;
    int n;

    flash_iap_erase_write_unlock #(
        .PROG_CYCLES(PR),
        .UNLOCK_CYCLES(UL),
        .PAGE_WORDS(32)
    ) dut_u (
        .mclk(mclk),
        .nrst(nrst),
        .bus_req(bus_req),
        .reg_rdata_q(reg_rdata_q),
        .flash_cmd_q(flash_cmd_q),
        .flash_buf_idx(flash_buf_idx),
        .flash_buf_data_q(flash_buf_data_q),
        .flash_buf_loaded_q(flash_buf_loaded_q),
        .cpu_stall_q(cpu_stall_q)
    );

    flash_array_model model_u (
        .mclk(mclk),
        .nrst(nrst),
        .flash_cmd(flash_cmd_q),
        .buf_idx(flash_buf_idx),
        .buf_data(flash_buf_data_q),
        .buf_loaded(flash_buf_loaded_q)
    );

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // strobe is left up; the next call or idle() takes it down
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
    endtask

    task automatic idle();
        bus_req <= '0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        bus_req <= '0;
        @(negedge mclk);
        d = reg_rdata_q;
        @(posedge mclk);
    endtask

    task automatic unlock(input logic [7:0] last);
        wr(`OFS_CTRL, 8'h68);
        wr(`OFS_W1_LO, 8'h00);
        wr(`OFS_W2_LO, 8'h0d);
        wr(`OFS_W3_LO, 8'hc3);
        wr(`OFS_W1_HI, 8'h04);
        wr(`OFS_W2_HI, 8'h09);
        wr(`OFS_W3_HI, last);
        idle();
    endtask

    // launch edge has just passed; count cycles with the cpu held
    task automatic run_op(input logic er, input logic [7:0] pg);
        bus_req <= '0;
        @(negedge mclk);
        chk(flash_cmd_q.erase, er);
        chk(flash_cmd_q.prog, !er);
        chk(flash_cmd_q.page, pg);
        n = 0;
        while (cpu_stall_q === 1'b1 && n < 200) begin
            n++;
            @(negedge mclk);
        end
        chk(n, PR + 1);
        @(posedge mclk);
        rd(`OFS_CTRL, rv);
        chk(rv[2], 1'b0);
    endtask

    task automatic t_regs();
        for (int a = 6; a < 12; a++) begin
            rd(a[3:0], rv);
            chk(rv, 8'h00);
            wr(a[3:0], 8'h5a ^ 8'(a));
            rd(a[3:0], rv);
            chk(rv, 8'h5a ^ 8'(a));
        end
        rd(4'hd, rv);
        chk(rv, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_unlock();
        unlock(8'h40);
        rd(`OFS_CTRL, rv);
        chk(rv[7], 1'b1);
        chk(rv[3], 1'b1);
        repeat (UL) @(posedge mclk);
        rd(`OFS_CTRL, rv);
        chk(rv[3], 1'b0);
        chk(rv[7], 1'b1);
        $display("test unlock done");
    endtask

    task automatic t_erase_write();
        wr(`OFS_ADDR_LO, 8'ha0);
        wr(`OFS_ADDR_HI, 8'h05);
        wr(`OFS_CTRL, 8'h94);
        run_op(1'b1, 8'h2d);
        chk(model_u.mem[8'h2d][7], 16'h0000);
        wr(`OFS_ADDR_LO, 8'ha0);
        for (int i = 0; i < 32; i++) begin
            wr(`OFS_W0_LO, 8'(i));
            wr(`OFS_W0_HI, 8'h10);
        end
        idle();
        rd(`OFS_ADDR_LO, rv);
        chk(rv, 8'hbf);
        repeat (40) @(posedge mclk);
        for (int i = 0; i < 31; i++) begin
            chk(model_u.buf_seen[i], {8'h10, 8'(i)});
        end
        chk(model_u.buf_seen[31], 16'h101f);
        chk(model_u.loaded_seen[31], 1'b1);
        wr(`OFS_CTRL, 8'h84);
        run_op(1'b0, 8'h2d);
        chk(model_u.mem[8'h2d][3], 16'h1003);
        wr(`OFS_CLEAR, 8'h01);
        idle();
        repeat (40) @(posedge mclk);
        rd(`OFS_CLEAR, rv);
        chk(rv[0], 1'b0);
        chk(model_u.loaded_seen[0], 1'b0);
        chk(model_u.loaded_seen[31], 1'b0);
        $display("test erase_write done");
    endtask

    task automatic t_lock();
        wr(`OFS_CTRL, 8'h00);
        rd(`OFS_CTRL, rv);
        chk(rv[7], 1'b0);
        wr(`OFS_CTRL, 8'h80);
        rd(`OFS_CTRL, rv);
        chk(rv[7], 1'b0);
        wr(`OFS_CTRL, 8'h14);
        idle();
        chk(cpu_stall_q, 1'b0);
        unlock(8'h41);
        repeat (UL) @(posedge mclk);
        rd(`OFS_CTRL, rv);
        chk(rv[7], 1'b0);
        chk(rv[3], 1'b0);
        $display("test lock done");
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        close_out();
    end

    initial begin
        error_cnt = 0;
        tests_run = 0;
        nrst = 1'b0;
        bus_req = '0;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_unlock();
        t_erase_write();
        t_lock();
        close_out();
    end
endmodule

`default_nettype wire
